// ### bench/sbcfg_i2c_host.sv
`default_nettype none
module sbcfg_i2c_host
#(
   parameter int QTR = 5
)
(
   // clock
   input  wire logic clock_in,
   // target drive of the data pin
   input  wire logic sda_in,
   input  wire logic sda_oe_n_in,
   // wire levels
   output logic      scl_out,
   output logic      sda_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic drive;

   // pull-up: low whenever either party pulls low
   assign sda_out = drive & (sda_oe_n_in | sda_in);

   initial
   begin
      drive = 1'b1;
      scl_out = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask

   // also serves as repeated start from a low clock
   task automatic start();
      drive = 1'b1;
      tick(QTR);
      scl_out = 1'b1;
      tick(QTR);
      drive = 1'b0;
      tick(QTR);
      scl_out = 1'b0;
      tick(QTR);
   endtask

   task automatic stop();
      drive = 1'b0;
      tick(QTR);
      scl_out = 1'b1;
      tick(QTR);
      drive = 1'b1;
      tick(QTR);
   endtask

   // low phase of 2*QTR keeps clear of the target's 3-cycle latency
   task automatic clk_bit(input logic b, output logic s);
      drive = b;
      tick(QTR);
      scl_out = 1'b1;
      tick(QTR);
      s = sda_out;
      tick(QTR);
      scl_out = 1'b0;
      tick(QTR);
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], s);
      clk_bit(1'b1, ack);
   endtask

   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(1'b1, d[i]);
      clk_bit(nack, s);
   endtask
endmodule // sbcfg_i2c_host
`default_nettype wire

// ### bench/tb_sbcfg_top.sv
`include "sbcfg_cfg.svh"
`default_nettype none
module tb_sbcfg_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clock_in, srst_in, scl, sda_line, sda_o, sda_oe_n;
   logic [6:0] strap_addr, addr_out, dev;
   logic       strap_io, err_ev, lock, load_done;
   logic       cont, crc, io, reload, full_rst, core_rst, ack;
   logic [1:0] lanes, lc;
   logic [7:0] n_reload, n_full, n_core, rd;
   int         bad_count, comparisons;

   sbcfg_top DUT (.clock_in(clock_in), .srst_in(srst_in), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
      .strap_address_in(strap_addr), .strap_io_1v8_in(strap_io),
      .error_event_in(err_ev), .link_lock_in(lock),
      .rom_load_done_in(load_done), .local_bus_address_out(addr_out),
      .continuous_lane_clock_out(cont), .lane_count_out(lanes),
      .crc_tx_enable_out(crc), .io_1v8_out(io),
      .rom_reload_request_out(reload), .full_reset_out(full_rst),
      .core_reset_out(core_rst));

   sbcfg_i2c_host host (.clock_in(clock_in), .sda_in(sda_o),
      .sda_oe_n_in(sda_oe_n), .scl_out(scl), .sda_out(sda_line));

   always #50 clock_in = ~clock_in;

   // cycles each action pulse stands high
   always @(posedge clock_in)
   begin
      if (reload === 1'b1)
         n_reload <= n_reload + 8'h01;
      if (full_rst === 1'b1)
         n_full <= n_full + 8'h01;
      if (core_rst === 1'b1)
         n_core <= n_core + 8'h01;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // resets from the bank may swallow the acknowledge, hence chk
   task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d,
                         input logic chk);
      logic a0, a1, a2;
      host.start();
      host.put_byte({dev, 1'b0}, a0);
      host.put_byte(ofs, a1);
      host.put_byte(d, a2);
      host.stop();
      if (chk)
         check({5'h00, a0, a1, a2}, 8'h00);
   endtask

   task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
      logic a0, a1, a2;
      host.start();
      host.put_byte({dev, 1'b0}, a0);
      host.put_byte(ofs, a1);
      host.start();
      host.put_byte({dev, 1'b1}, a2);
      host.get_byte(1'b1, rd);
      host.stop();
      check({5'h00, a0, a1, a2}, 8'h00);
      check(rd, exp);
   endtask

   initial
   begin
      #6_000_000;
      bad_count++;
      give_verdict();
   end

   initial
   begin
      clock_in = 1'b0;
      srst_in = 1'b1;
      strap_addr = 7'h3a;
      strap_io = 1'b1;
      err_ev = 1'b0;
      lock = 1'b1;
      load_done = 1'b0;
      dev = 7'h3a;
      n_reload = 8'h00;
      n_full = 8'h00;
      n_core = 8'h00;
      repeat (2) @(negedge clock_in);
      srst_in = 1'b0;
      // second reset once straps have passed the synchronisers
      repeat (4) @(negedge clock_in);
      srst_in = 1'b1;
      repeat (2) @(negedge clock_in);
      srst_in = 1'b0;
      repeat (4) @(negedge clock_in);
      check({1'b0, addr_out}, 8'h3a);
      check({7'h00, cont}, 8'h00);
      check({6'h00, lanes}, 8'h03);
      check({7'h00, crc}, 8'h01);
      check({7'h00, io}, 8'h01);
      rd_chk(`SBCFG_OFS_ADDR, 8'h74);
      rd_chk(`SBCFG_OFS_RESET, 8'h00);
      rd_chk(`SBCFG_OFS_GENCFG, 8'h33);
      rd_chk(8'h05, 8'h00);
      // address override
      wr_reg(`SBCFG_OFS_ADDR, 8'h42, 1'b1);
      check({1'b0, addr_out}, 8'h3a);
      wr_reg(`SBCFG_OFS_ADDR, 8'h43, 1'b1);
      check({1'b0, addr_out}, 8'h21);
      dev = 7'h21;
      rd_chk(`SBCFG_OFS_ADDR, 8'h43);
      host.start();
      host.put_byte({7'h3a, 1'b0}, ack);
      host.stop();
      check({7'h00, ack}, 8'h01);
      wr_reg(`SBCFG_OFS_ADDR, 8'h00, 1'b1);
      check({1'b0, addr_out}, 8'h3a);
      dev = 7'h3a;
      // every lane code, with the other fields flipped
      for (int k = 0; k < 3; k++)
      begin
         lc = (k == 2) ? 2'b11 : 2'(k);
         wr_reg(`SBCFG_OFS_GENCFG, {2'b01, lc, 4'h0}, 1'b1);
         check({6'h00, lanes}, {6'h00, lc});
         check({5'h00, cont, crc, io}, 8'h04);
         rd_chk(`SBCFG_OFS_GENCFG, {2'b01, lc, 4'h0});
      end
      // self-clearing actions
      wr_reg(`SBCFG_OFS_RESET, 8'h04, 1'b1);
      check(n_reload, 8'h01);
      rd_chk(`SBCFG_OFS_RESET, 8'h00);
      wr_reg(`SBCFG_OFS_RESET, 8'h01, 1'b0);
      check(n_core, 8'h01);
      check(n_reload, 8'h01);
      check(n_full, 8'h00);
      rd_chk(`SBCFG_OFS_GENCFG, 8'h70);
      rd_chk(`SBCFG_OFS_RESET, 8'h00);
      wr_reg(`SBCFG_OFS_RESET, 8'hf8, 1'b1);
      rd_chk(`SBCFG_OFS_RESET, 8'hf8);
      wr_reg(`SBCFG_OFS_ADDR, 8'h43, 1'b1);
      dev = 7'h21;
      strap_addr = 7'h2c;
      strap_io = 1'b0;
      wr_reg(`SBCFG_OFS_RESET, 8'hfa, 1'b0);
      check(n_full, 8'h01);
      check({1'b0, addr_out}, 8'h2c);
      dev = 7'h2c;
      rd_chk(`SBCFG_OFS_GENCFG, 8'h32);
      rd_chk(`SBCFG_OFS_RESET, 8'h00);
      rd_chk(`SBCFG_OFS_ADDR, 8'h58);
      // latched and read-to-clear status
      rd_chk(`SBCFG_OFS_STATUS, 8'h02);
      err_ev = 1'b1;
      load_done = 1'b1;
      lock = 1'b0;
      @(negedge clock_in);
      err_ev = 1'b0;
      load_done = 1'b0;
      repeat (3) @(negedge clock_in);
      lock = 1'b1;
      rd_chk(`SBCFG_OFS_STATUS, 8'h05);
      rd_chk(`SBCFG_OFS_STATUS, 8'h02);
      give_verdict();
   end
endmodule // tb_sbcfg_top
`default_nettype wire

// ### design/sbcfg_i2c_target.sv
`default_nettype none
module sbcfg_i2c_target
(
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       srst_in,
   // serial pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n_out,
   // local side
   input  wire logic [6:0] local_addr_in,
   input  wire logic [7:0] rd_data_in,
   output logic [7:0]      peek_addr_out,
   output logic [7:0]      reg_addr_out,
   output logic [7:0]      wr_data_out,
   output logic            wr_stb_out,
   output logic            rd_stb_out
);
   logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   sbcfg_pkg::sbcfg_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] sh, next_sh, ptr, next_ptr, addr_q, next_addr;
   logic [7:0] wdata, next_wdata;
   logic       ptr_set, next_ptr_set, is_read, next_is_read;
   logic       acked, next_acked, oe_n, next_oe_n;
   logic       wr_stb, next_wr_stb, rd_stb, next_rd_stb;
   logic       start, stop, rise, fall;

   // pins are asynchronous: two flops before any use
   always_ff @(posedge clock_in)
   begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
   end

   assign start = scl_s2 && scl_d && sda_d && !sda_s2;
   assign stop  = scl_s2 && scl_d && !sda_d && sda_s2;
   assign rise  = scl_s2 && !scl_d;
   assign fall  = !scl_s2 && scl_d;

   always_comb
   begin
      next_state   = state;
      next_cnt     = cnt;
      next_sh      = sh;
      next_ptr     = ptr;
      next_addr    = addr_q;
      next_wdata   = wdata;
      next_ptr_set = ptr_set;
      next_is_read = is_read;
      next_acked   = acked;
      next_oe_n    = oe_n;
      next_wr_stb  = 1'b0;
      next_rd_stb  = 1'b0;
      if (start)
      begin
         next_state   = sbcfg_pkg::ST_ADDR;
         next_cnt     = 4'h0;
         next_ptr_set = 1'b0;
         next_oe_n    = 1'b1;
      end
      else if (stop)
      begin
         next_state = sbcfg_pkg::ST_IDLE;
         next_oe_n  = 1'b1;
      end
      else
      begin
         case (state)
            sbcfg_pkg::ST_ADDR, sbcfg_pkg::ST_WR_BYTE:
            begin
               if (rise)
               begin
                  next_sh  = {sh[6:0], sda_s2};
                  next_cnt = cnt + 4'h1;
               end
               else if (fall && cnt == 4'h8)
               begin
                  next_oe_n = 1'b0;
                  if (state == sbcfg_pkg::ST_ADDR)
                  begin
                     next_is_read = sh[0];
                     next_state   = sbcfg_pkg::ST_ADDR_ACK;
                     if (sh[7:1] != local_addr_in)
                     begin
                        next_oe_n  = 1'b1;
                        next_state = sbcfg_pkg::ST_IDLE;
                     end
                  end
                  else
                  begin
                     next_state = sbcfg_pkg::ST_WR_ACK;
                     if (!ptr_set)
                     begin
                        next_ptr     = sh;
                        next_ptr_set = 1'b1;
                     end
                     else
                     begin
                        next_wr_stb = 1'b1;
                        next_addr   = ptr;
                        next_wdata  = sh;
                        next_ptr    = ptr + 8'h01;
                     end
                  end
               end
            end
            sbcfg_pkg::ST_ADDR_ACK, sbcfg_pkg::ST_WR_ACK,
            sbcfg_pkg::ST_RD_ACK:
            begin
               if (rise && state == sbcfg_pkg::ST_RD_ACK)
                  next_acked = !sda_s2;
               else if (fall)
               begin
                  next_oe_n  = 1'b1;
                  next_cnt   = 4'h0;
                  next_state = sbcfg_pkg::ST_WR_BYTE;
                  if ((state == sbcfg_pkg::ST_ADDR_ACK && is_read) ||
                      (state == sbcfg_pkg::ST_RD_ACK && acked))
                  begin
                     // byte taken now; the read side effect follows
                     next_sh     = rd_data_in;
                     next_oe_n   = rd_data_in[7];
                     next_rd_stb = 1'b1;
                     next_addr   = ptr;
                     next_ptr    = ptr + 8'h01;
                     next_state  = sbcfg_pkg::ST_RD_BYTE;
                  end
                  else if (state == sbcfg_pkg::ST_RD_ACK)
                     next_state = sbcfg_pkg::ST_IDLE;
               end
            end
            sbcfg_pkg::ST_RD_BYTE:
            begin
               if (fall)
               begin
                  if (cnt == 4'h7)
                  begin
                     next_oe_n  = 1'b1;
                     next_state = sbcfg_pkg::ST_RD_ACK;
                  end
                  else
                  begin
                     next_sh   = {sh[6:0], 1'b1};
                     next_oe_n = sh[6];
                     next_cnt  = cnt + 4'h1;
                  end
               end
            end
            sbcfg_pkg::ST_IDLE:
               next_oe_n = 1'b1;
            default:
            begin
               next_state = sbcfg_pkg::ST_IDLE;
               next_oe_n  = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         state   <= sbcfg_pkg::ST_IDLE;
         cnt     <= 4'h0;
         sh      <= 8'h00;
         ptr     <= 8'h00;
         addr_q  <= 8'h00;
         wdata   <= 8'h00;
         ptr_set <= 1'b0;
         is_read <= 1'b0;
         acked   <= 1'b0;
         oe_n    <= 1'b1;
         wr_stb  <= 1'b0;
         rd_stb  <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         cnt     <= next_cnt;
         sh      <= next_sh;
         ptr     <= next_ptr;
         addr_q  <= next_addr;
         wdata   <= next_wdata;
         ptr_set <= next_ptr_set;
         is_read <= next_is_read;
         acked   <= next_acked;
         oe_n    <= next_oe_n;
         wr_stb  <= next_wr_stb;
         rd_stb  <= next_rd_stb;
      end
   end

   // open drain: only ever pulls low
   assign sda_out       = 1'b0;
   assign sda_oe_n_out  = oe_n;
   assign peek_addr_out = ptr;
   assign reg_addr_out  = addr_q;
   assign wr_data_out   = wdata;
   assign wr_stb_out    = wr_stb;
   assign rd_stb_out    = rd_stb;
endmodule // sbcfg_i2c_target
`default_nettype wire

// ### design/sbcfg_top.sv
// What this block does
// R1: read-to-clear fields return their value, then clear because of that read.
// R2: self-clearing bits accept writes and return to zero by themselves.
// R3: latched-low/high status captures the level and holds until read.
// R4: strap-set fields take their start value from sampled strap pins.
// R5: identity register bits 7:1 always show the current local bus address.
// R6: override 0 keeps strapped address read-only; override 1 lets software set it.
// R7: writing 1 to reload bit restarts ROM load; bit clears itself.
// R8: full digital reset bit resets all logic and registers, then clears.
// R9: core digital reset bit resets logic but keeps registers, then clears.
// R10: clock-lane bit: 0 non-continuous, 1 continuous; defaults to 0.
// R11: lane count 00 one, 01 two, 11 four lanes; defaults four.
// R12: transmit CRC enable bit turns CRC on when 1; defaults enabled.
// R13: general config bit 0 shows strapped I/O level and is writable.
// R14: reset and reload bits read 0 once their one-cycle pulse issued.
`include "sbcfg_cfg.svh"
`default_nettype none
module sbcfg_top
(
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       srst_in,
   // serial control pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n_out,
   // strap pins
   input  wire logic [6:0] strap_address_in,
   input  wire logic       strap_io_1v8_in,
   // status events from device logic
   input  wire logic       error_event_in,
   input  wire logic       link_lock_in,
   input  wire logic       rom_load_done_in,
   // configuration outputs
   output logic [6:0]      local_bus_address_out,
   output logic            continuous_lane_clock_out,
   output logic [1:0]      lane_count_out,
   output logic            crc_tx_enable_out,
   output logic            io_1v8_out,
   // action pulses
   output logic            rom_reload_request_out,
   output logic            full_reset_out,
   output logic            core_reset_out
);
   logic [6:0] strap_a_s1, strap_a_s2;
   logic       strap_io_s1, strap_io_s2;
   logic [7:0] peek_addr, reg_addr, wr_data, rd_data;
   logic       wr_stb, rd_stb, regs_rst;
   logic       wr_addr, wr_rst, wr_gen, rd_sta;

   logic [6:0] addr_q, next_addr_q;
   logic       ovr, next_ovr, taken, next_taken;
   logic [7:0] rstc, next_rstc;
   logic [7:1] gen_hi, next_gen_hi;
   logic       gen_io, next_gen_io;
   logic       lh, next_lh, ll_seen, next_ll_seen, rc, next_rc;

   sbcfg_i2c_target u_target
   (
      .clock_in      (clock_in),
      .srst_in       (regs_rst),
      .scl_in        (scl_in),
      .sda_in        (sda_in),
      .sda_out       (sda_out),
      .sda_oe_n_out  (sda_oe_n_out),
      .local_addr_in (addr_q),
      .rd_data_in    (rd_data),
      .peek_addr_out (peek_addr),
      .reg_addr_out  (reg_addr),
      .wr_data_out   (wr_data),
      .wr_stb_out    (wr_stb),
      .rd_stb_out    (rd_stb)
   );

   // strap pins are asynchronous levels
   always_ff @(posedge clock_in)
   begin
      strap_a_s1  <= strap_address_in;
      strap_a_s2  <= strap_a_s1;
      strap_io_s1 <= strap_io_1v8_in;
      strap_io_s2 <= strap_io_s1;
   end

   // full digital reset also clears every register
   assign regs_rst = srst_in || rstc[`SBCFG_RST_FULL_BIT]; // [R8]
   assign wr_addr  = wr_stb && reg_addr == `SBCFG_OFS_ADDR;
   assign wr_rst   = wr_stb && reg_addr == `SBCFG_OFS_RESET;
   assign wr_gen   = wr_stb && reg_addr == `SBCFG_OFS_GENCFG;
   assign rd_sta   = rd_stb && reg_addr == `SBCFG_OFS_STATUS;

   always_comb
   begin
      next_taken   = 1'b1;
      next_ovr     = ovr;
      next_addr_q  = addr_q;
      next_gen_hi  = gen_hi;
      next_gen_io  = gen_io;
      // action bits live one cycle only
      next_rstc    = {rstc[7:3], 3'b000}; // [R2] [R14]
      if (!taken)
      begin
         next_addr_q = strap_a_s2; // [R4]
         next_gen_io = strap_io_s2; // [R4] [R13]
      end
      else if (!ovr)
         next_addr_q = strap_a_s2; // [R6]
      if (wr_addr)
      begin
         next_ovr = wr_data[`SBCFG_ADDR_OVR_BIT];
         if (wr_data[`SBCFG_ADDR_OVR_BIT])
            next_addr_q = wr_data[7:1]; // [R6]
      end
      if (wr_rst)
         next_rstc = wr_data; // [R7] [R8] [R9]
      if (wr_gen)
      begin
         next_gen_hi = wr_data[7:1]; // [R10] [R11] [R12]
         next_gen_io = wr_data[`SBCFG_GEN_IO_BIT]; // [R13]
      end
      // set wins over the read that would clear
      next_lh      = error_event_in || (lh && !rd_sta); // [R3]
      next_ll_seen = !link_lock_in || (ll_seen && !rd_sta); // [R3]
      next_rc      = rom_load_done_in || (rc && !rd_sta); // [R1]
   end

   always_ff @(posedge clock_in)
   begin
      if (regs_rst)
      begin
         taken   <= 1'b0;
         ovr     <= 1'b0;
         addr_q  <= 7'h00;
         rstc    <= {`SBCFG_RST_RSVD_RST, 3'b000};
         gen_hi  <= `SBCFG_GEN_RST_HI;
         gen_io  <= 1'b0;
         lh      <= 1'b0;
         ll_seen <= 1'b0;
         rc      <= 1'b0;
      end
      else
      begin
         taken   <= next_taken;
         ovr     <= next_ovr;
         addr_q  <= next_addr_q;
         rstc    <= next_rstc;
         gen_hi  <= next_gen_hi;
         gen_io  <= next_gen_io;
         lh      <= next_lh;
         ll_seen <= next_ll_seen;
         rc      <= next_rc;
      end
   end

   always_comb
   begin
      case (peek_addr)
         `SBCFG_OFS_ADDR:   rd_data = {addr_q, ovr}; // [R5]
         `SBCFG_OFS_RESET:  rd_data = rstc; // [R14]
         `SBCFG_OFS_GENCFG: rd_data = {gen_hi, gen_io};
         // latched-low bit reads 0 once the lock dropped
         `SBCFG_OFS_STATUS: rd_data = {5'h00, rc,
                                       link_lock_in && !ll_seen, lh};
         default:           rd_data = 8'h00;
      endcase
   end

   assign local_bus_address_out     = addr_q; // [R5]
   assign continuous_lane_clock_out = gen_hi[`SBCFG_GEN_CONT_BIT]; // [R10]
   assign lane_count_out            =
      gen_hi[`SBCFG_GEN_LANE_LSB+1:`SBCFG_GEN_LANE_LSB]; // [R11]
   assign crc_tx_enable_out         = gen_hi[`SBCFG_GEN_CRC_BIT]; // [R12]
   assign io_1v8_out                = gen_io;
   assign rom_reload_request_out    = rstc[`SBCFG_RST_RELOAD_BIT]; // [R7]
   assign full_reset_out            = rstc[`SBCFG_RST_FULL_BIT]; // [R8]
   assign core_reset_out            = rstc[`SBCFG_RST_CORE_BIT]; // [R9]

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (srst_in);

   property p_rc_clear;
      rd_sta && !rom_load_done_in && !full_reset_out |=> !rc;
   endproperty
   a_rc_clear: assert property (p_rc_clear) // [R1]
      else $error("read-to-clear flag survived its read");

   property p_lh_hold;
      error_event_in && !full_reset_out |=> lh ##1
         (lh || $past(rd_sta));
   endproperty
   a_lh_hold: assert property (p_lh_hold) // [R3]
      else $error("latched-high flag lost before read");

   property p_strap;
      taken && !$past(taken) && !$past(regs_rst)
         |-> io_1v8_out == $past(strap_io_s2);
   endproperty
   a_strap: assert property (p_strap) // [R4]
      else $error("strapped level not captured at start");

   property p_no_ovr;
      taken && !ovr && !wr_addr && !full_reset_out
         |=> local_bus_address_out == $past(strap_a_s2);
   endproperty
   a_no_ovr: assert property (p_no_ovr) // [R6]
      else $error("address left strap while override is 0");

   property p_reload;
      wr_rst && wr_data[`SBCFG_RST_RELOAD_BIT] && !full_reset_out
         |=> rom_reload_request_out ##1 !rom_reload_request_out;
   endproperty
   a_reload: assert property (p_reload) // [R7]
      else $error("reload pulse wrong or not self-cleared");

   property p_full;
      wr_rst && wr_data[`SBCFG_RST_FULL_BIT] && !full_reset_out
         |=> full_reset_out ##1 (!full_reset_out && lane_count_out == 2'h3
         && crc_tx_enable_out && !ovr);
   endproperty
   a_full: assert property (p_full) // [R8]
      else $error("full reset did not clear registers");

   property p_core;
      wr_rst && wr_data[`SBCFG_RST_CORE_BIT] && !wr_data[1]
         && !full_reset_out |=> core_reset_out && $stable(gen_hi)
         ##1 !core_reset_out;
   endproperty
   a_core: assert property (p_core) // [R9]
      else $error("core reset touched registers or stuck");

   property p_gen_write;
      wr_gen && !full_reset_out |=>
         continuous_lane_clock_out == $past(wr_data[6]) &&
         lane_count_out == $past(wr_data[5:4]) &&
         crc_tx_enable_out == $past(wr_data[1]);
   endproperty
   a_gen_write: assert property (p_gen_write) // [R10] [R11] [R12]
      else $error("general configuration write not applied");

   property p_sc_zero;
      wr_rst && !full_reset_out |=> ##1 rstc[2:0] == 3'b000;
   endproperty
   a_sc_zero: assert property (p_sc_zero) // [R2] [R14]
      else $error("self-clearing bits still read back set");
endmodule // sbcfg_top
`default_nettype wire

// ### shared/sbcfg_cfg.svh
`ifndef SBCFG_CFG_SVH
`define SBCFG_CFG_SVH

// register offsets
`define SBCFG_OFS_ADDR        8'h00
`define SBCFG_OFS_RESET       8'h01
`define SBCFG_OFS_GENCFG      8'h02
`define SBCFG_OFS_STATUS      8'h0f

// local_address_control fields
`define SBCFG_ADDR_OVR_BIT    0
`define SBCFG_ADDR_LSB        1

// reset_control fields
`define SBCFG_RST_CORE_BIT    0
`define SBCFG_RST_FULL_BIT    1
`define SBCFG_RST_RELOAD_BIT  2
`define SBCFG_RST_RSVD_RST    5'h00

// general_configuration fields and reset values
`define SBCFG_GEN_IO_BIT      0
`define SBCFG_GEN_CRC_BIT     1
`define SBCFG_GEN_LANE_LSB    4
`define SBCFG_GEN_CONT_BIT    6
`define SBCFG_GEN_RST_HI      7'h19

// status fields
`define SBCFG_STA_LH_BIT      0
`define SBCFG_STA_LL_BIT      1
`define SBCFG_STA_RC_BIT      2

`endif

// ### shared/sbcfg_pkg.sv
`default_nettype none
package sbcfg_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK
   } sbcfg_state_t;
endpackage
`default_nettype wire
